// ===== sector_guard_map.vh
`ifndef SECTOR_GUARD_MAP_VH
`define SECTOR_GUARD_MAP_VH

// Opcodes
`define OP_GLOBAL_LOCK        8'h7E
`define OP_GLOBAL_UNLOCK      8'h98
`define OP_SECTOR_LOCK        8'h36
`define OP_SECTOR_UNLOCK      8'h39
`define OP_LOCK_BIT_READ      8'h3D
`define OP_SET_POINTER        8'hFB
`define OP_SET_POINTER_WIDE   8'hE3
`define OP_WRITE_ANY_REG      8'h71
`define OP_READ_ANY_REG       8'h65
`define OP_CHIP_ERASE         8'hCE
`define OP_PAGE_PROGRAM       8'h02
`define OP_SECTOR_ERASE       8'h20
`define OP_HALF_BLOCK_ERASE   8'h52
`define OP_BLOCK_ERASE        8'hD8

// Register address used by write/read any register for the pointer setting
`define POINTER_REG_ADDR      32'h00000780

// Pointer region setting field positions
`define PTR_DIR_BIT           9
`define PTR_EN_N_BIT          10
`define PTR_ALL_BIT           11
`define PTR_SECT_LSB          12

// Pointer register reset (erased) value: guard disabled
`define PTR_RESET_VALUE       32'hFFFFFFFF

// Lock boot default bit position in the region guard config
`define LOCK_BOOT_BIT         4

`endif

// ===== bit_sync.v
`timescale 1ns/1ps
module bit_sync #(
    parameter WIDTH = 1
) (
    input wire clk_in,
    input wire rst_b_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// ===== sector_lock_array.v
`timescale 1ns/1ps
module sector_lock_array #(
    parameter NUM_BITS = 542,
    parameter IDX_W = 10
) (
    input wire clk_in,
    input wire rst_b_in,
    input wire load_default_in,
    input wire default_val_in,
    input wire set_one_in,
    input wire clr_one_in,
    input wire set_all_in,
    input wire clr_all_in,
    input wire [IDX_W-1:0] idx_in,
    input wire [IDX_W-1:0] rd_idx_in,
    output wire rd_bit_out
);
    wire [NUM_BITS-1:0] lock_w;

    // One flip-flop per unit keeps each lock independent, and each
    // bit has its own single driver
    genvar g;
    generate
        for (g = 0; g < NUM_BITS; g = g + 1) begin : lk
            reg bit_r;
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    bit_r <= 1'b0;
                end else if (load_default_in) begin
                    bit_r <= default_val_in;
                end else if (set_all_in) begin
                    bit_r <= 1'b1;
                end else if (clr_all_in) begin
                    bit_r <= 1'b0;
                end else if (set_one_in && idx_in == g) begin
                    bit_r <= 1'b1;
                end else if (clr_one_in && idx_in == g) begin
                    bit_r <= 1'b0;
                end
            end
            assign lock_w[g] = bit_r;
        end
    endgenerate

    assign rd_bit_out = (rd_idx_in < NUM_BITS) ? lock_w[rd_idx_in] : 1'b0;
endmodule

// ===== sector_lock_and_pointer_guard.v
`timescale 1ns/1ps
`include "sector_guard_map.vh"

// Contract
// - One volatile lock bit per unit
// - Lock commands write zero to lock bits
// - Unlock commands write one to lock bits
// - Lock read returns addressed unit bit
// - Blocks get one bit; end blocks per sector
// - Lock bit zero rejects program and erase
// - Resets load lock bits from boot default
// - Pointer is nonvolatile, survives resets
// - Pointer guard ORed with selected scheme
// - Pointer written by set-pointer or write-any-register
// - Bit ten low enables pointer guard
// - Reserved pointer bits read as ones
// - Boundary sector from upper address bits, unprotected
// - Bit nine picks bottom-up or top-down
// - Bit eleven protects every sector
// - Set-pointer ignored while suspended
// - Set-pointer ignored when unlock flag zero
// - Read-any-register returns pointer register
// - Erase fails if any part protected; end-block erase checks only the addressed sector's lock bit
// - Chip erase ignored, error set, when enabled
// - Pointer unchangeable while unlock flag zero
// - Lock boot default is config bit four
module sector_lock_and_pointer_guard #(
    parameter ADDR_W = 25,
    parameter NUM_BLOCKS = 512,
    parameter SECT_PER_BLK = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Serial link pins
    input wire sclk_in,
    input wire cs_b_in,
    input wire si_in,
    output wire so_out,
    output wire so_oe_out,
    // Device state
    input wire soft_reset_in,
    input wire suspended_in,
    input wire config_unlock_flag_in,
    input wire scheme_select_bit_in,
    input wire four_byte_mode_in,
    input wire [7:0] region_guard_config_in,
    input wire legacy_protect_in,
    // Array operation results and pointer setting
    output wire array_op_ok_out,
    output wire array_op_done_out,
    output wire program_error_out,
    output wire erase_error_out,
    output wire [31:0] pointer_region_setting_out
);
    localparam NUM_BITS = NUM_BLOCKS - 2 + 2 * SECT_PER_BLK;
    localparam SECT_W = ADDR_W - 12;

    // ------------------------------------------------------------
    // Pin synchronisation and clock edge detection
    // ------------------------------------------------------------
    wire [2:0] pins_s;
    reg sclk_d_r;
    bit_sync #(.WIDTH(3)) pin_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in({sclk_in, ~cs_b_in, si_in}),
        .sync_out(pins_s)
    );
    wire sclk_s = pins_s[2];
    wire sel_s = pins_s[1];
    wire si_s = pins_s[0];
    wire rise = sclk_s & ~sclk_d_r;
    wire fall = ~sclk_s & sclk_d_r;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    localparam ST_OP = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_DATA = 4'b0100;
    localparam ST_OUT = 4'b1000;

    reg [3:0] state_r;
    reg [7:0] op_r;
    reg [31:0] shift_r;
    reg [5:0] cnt_r;
    reg [31:0] addr_r;
    // Starts in the erased state; it models nonvolatile cells, so no
    // reset of any kind touches it
    reg [31:0] pointer_r = `PTR_RESET_VALUE;
    reg [31:0] out_r;
    reg so_r;
    reg oe_r;
    reg ok_r;
    reg done_r;
    reg perr_r;
    reg eerr_r;
    reg boot_load_r;

    wire [31:0] shift_nxt = {shift_r[30:0], si_s};
    wire wide_op = (op_r == `OP_SET_POINTER_WIDE) | four_byte_mode_in;
    wire [5:0] addr_bits = wide_op ? 6'd32 : 6'd24;

    // ------------------------------------------------------------
    // Address to lock index: end blocks split per 4KB sector
    // ------------------------------------------------------------
    function [9:0] unit_idx;
        input [31:0] a;
        reg [15:0] blk;
        reg [31:0] full;
        begin
            blk = a[31:16];
            if (blk == 16'h0000) begin
                full = {28'h0000000, a[15:12]};
            end else if (blk == NUM_BLOCKS - 1) begin
                full = SECT_PER_BLK + NUM_BLOCKS - 2
                    + {28'h0000000, a[15:12]};
            end else begin
                full = SECT_PER_BLK - 1 + {16'h0000, blk};
            end
            unit_idx = full[9:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Pointer guard check for a single 4KB sector
    // ------------------------------------------------------------
    wire ptr_en = ~pointer_r[`PTR_EN_N_BIT];
    wire [SECT_W-1:0] ptr_sect = pointer_r[`PTR_SECT_LSB +: SECT_W];

    function ptr_prot;
        input [SECT_W-1:0] s;
        begin
            if (!ptr_en) begin
                ptr_prot = 1'b0;
            end else if (pointer_r[`PTR_ALL_BIT]) begin
                ptr_prot = 1'b1;
            end else if (pointer_r[`PTR_DIR_BIT]) begin
                ptr_prot = s < ptr_sect;
            end else begin
                ptr_prot = s > ptr_sect;
            end
        end
    endfunction

    // Erase span in sectors: range check instead of a sector walk
    wire [SECT_W-1:0] tgt_sect = addr_r[`PTR_SECT_LSB +: SECT_W];
    reg [SECT_W-1:0] span_lo;
    reg [SECT_W-1:0] span_hi;
    always @* begin
        span_lo = tgt_sect;
        span_hi = tgt_sect;
        if (op_r == `OP_BLOCK_ERASE) begin
            span_lo = {tgt_sect[SECT_W-1:4], 4'h0};
            span_hi = {tgt_sect[SECT_W-1:4], 4'hF};
        end else if (op_r == `OP_HALF_BLOCK_ERASE) begin
            span_lo = {tgt_sect[SECT_W-1:3], 3'h0};
            span_hi = {tgt_sect[SECT_W-1:3], 3'h7};
        end
    end
    // Any protected sector in span: both span ends are enough since
    // the pointer region is a single contiguous range
    wire span_ptr = ptr_prot(span_lo) | ptr_prot(span_hi);

    // Lock bit for the addressed unit; a block erase over an end
    // block is judged by the addressed sector's bit only (trade-off)
    wire lock_bit;
    wire [9:0] tgt_idx = unit_idx(addr_r);
    wire scheme_prot = scheme_select_bit_in ? ~lock_bit
                                            : legacy_protect_in;
    wire prot_any = span_ptr | scheme_prot;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire addr_done = (state_r == ST_ADDR) & rise
                     & (cnt_r == addr_bits - 6'd1);
    wire is_lock = op_r == `OP_SECTOR_LOCK;
    wire is_unlock = op_r == `OP_SECTOR_UNLOCK;
    wire is_ptr = (op_r == `OP_SET_POINTER)
                  | (op_r == `OP_SET_POINTER_WIDE);
    wire is_pgm = op_r == `OP_PAGE_PROGRAM;
    wire is_erase = (op_r == `OP_SECTOR_ERASE)
                    | (op_r == `OP_HALF_BLOCK_ERASE)
                    | (op_r == `OP_BLOCK_ERASE);
    wire ptr_allowed = ~suspended_in & config_unlock_flag_in;
    wire war_ptr = (op_r == `OP_WRITE_ANY_REG)
                   & (addr_r == `POINTER_REG_ADDR);
    wire op_done = sel_s & (state_r == ST_OP) & rise & (cnt_r == 6'd7);
    // Pointer writes: set-pointer once its address is in, write-any-
    // register on its 32nd data bit
    wire ptr_set_go = sel_s & (state_r == ST_DATA) & is_ptr
                      & ptr_allowed;
    wire ptr_war_go = sel_s & (state_r == ST_OUT) & war_ptr & rise
                      & ptr_allowed & (cnt_r == 6'd31);

    wire set_all = op_done & (shift_nxt[7:0] == `OP_GLOBAL_UNLOCK);
    wire clr_all = op_done & (shift_nxt[7:0] == `OP_GLOBAL_LOCK);
    wire chip_erase = op_done & (shift_nxt[7:0] == `OP_CHIP_ERASE);
    reg lk_set_r;
    reg lk_clr_r;
    wire load_default = boot_load_r;

    sector_lock_array #(.NUM_BITS(NUM_BITS), .IDX_W(10)) locks (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .load_default_in(load_default),
        .default_val_in(~region_guard_config_in[`LOCK_BOOT_BIT]),
        .set_one_in(lk_set_r),
        .clr_one_in(lk_clr_r),
        .set_all_in(set_all),
        .clr_all_in(clr_all),
        .idx_in(tgt_idx),
        .rd_idx_in(tgt_idx),
        .rd_bit_out(lock_bit)
    );

    // ------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= ST_OP;
            op_r <= 8'h00;
            shift_r <= 32'h00000000;
            cnt_r <= 6'd0;
            addr_r <= 32'h00000000;
            out_r <= 32'h00000000;
            so_r <= 1'b0;
            oe_r <= 1'b0;
            ok_r <= 1'b0;
            done_r <= 1'b0;
            perr_r <= 1'b0;
            eerr_r <= 1'b0;
            boot_load_r <= 1'b1;
            lk_set_r <= 1'b0;
            lk_clr_r <= 1'b0;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            boot_load_r <= soft_reset_in;
            done_r <= 1'b0;
            lk_set_r <= 1'b0;
            lk_clr_r <= 1'b0;
            if (!sel_s) begin
                state_r <= ST_OP;
                cnt_r <= 6'd0;
                oe_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_OP: begin
                        if (rise) begin
                            shift_r <= shift_nxt;
                            cnt_r <= cnt_r + 6'd1;
                            if (cnt_r == 6'd7) begin
                                op_r <= shift_nxt[7:0];
                                cnt_r <= 6'd0;
                                state_r <= ST_ADDR;
                                if (chip_erase) begin
                                    done_r <= 1'b1;
                                    // A stale program error must not
                                    // stand beside a fresh ok
                                    perr_r <= 1'b0;
                                    ok_r <= ~ptr_en;
                                    eerr_r <= ptr_en;
                                end
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (rise) begin
                            shift_r <= shift_nxt;
                            cnt_r <= cnt_r + 6'd1;
                            if (addr_done) begin
                                addr_r <= wide_op ? shift_nxt
                                    : {8'h00, shift_nxt[23:0]};
                                cnt_r <= 6'd0;
                                state_r <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        state_r <= ST_OUT;
                        cnt_r <= 6'd0;
                        if (is_lock) begin
                            lk_clr_r <= 1'b1;
                        end
                        if (is_unlock) begin
                            lk_set_r <= 1'b1;
                        end
                        if (op_r == `OP_LOCK_BIT_READ) begin
                            out_r <= {{24{1'b0}}, {8{lock_bit}}};
                        end else if (op_r == `OP_READ_ANY_REG) begin
                            out_r <= pointer_r;
                        end else begin
                            out_r <= 32'h00000000;
                        end
                        if (is_pgm || is_erase) begin
                            done_r <= 1'b1;
                            ok_r <= ~prot_any;
                            perr_r <= is_pgm & prot_any;
                            eerr_r <= is_erase & prot_any;
                        end
                    end
                    ST_OUT: begin
                        if (war_ptr && rise && ptr_allowed) begin
                            shift_r <= shift_nxt;
                            cnt_r <= cnt_r + 6'd1;
                        end
                        if (fall && !war_ptr) begin
                            so_r <= out_r[31];
                            oe_r <= 1'b1;
                            out_r <= {out_r[30:0], out_r[31]};
                        end
                    end
                    default: state_r <= ST_OP;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Nonvolatile pointer register
    // ------------------------------------------------------------
    // No reset: the pointer must outlive hardware and software resets
    always @(posedge clk_in) begin
        if (ptr_set_go) begin
            // Reserved bits held as ones
            pointer_r <= {addr_r[31:9], 9'h1FF};
        end else if (ptr_war_go) begin
            pointer_r <= shift_nxt | 32'h000001FF;
        end
    end

    assign so_out = so_r;
    assign so_oe_out = oe_r;
    assign array_op_ok_out = ok_r;
    assign array_op_done_out = done_r;
    assign program_error_out = perr_r;
    assign erase_error_out = eerr_r;
    assign pointer_region_setting_out = pointer_r;
endmodule

// ===== sector_guard_props.sv
`timescale 1ns/1ps
module sector_guard_props (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Watched pins
    input wire cs_b_in,
    input wire config_unlock_flag_in,
    input wire so_oe_out,
    input wire array_op_ok_out,
    input wire array_op_done_out,
    input wire program_error_out,
    input wire erase_error_out,
    input wire [31:0] pointer_region_setting_out
);
    // ----------------------------------
    // Port checks
    // ----------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_done_one_pulse: assert property (
        array_op_done_out |=> !array_op_done_out)
        else $error("done held too long");
    a_result_on_done: assert property (
        !$stable({array_op_ok_out, program_error_out, erase_error_out})
        |-> array_op_done_out)
        else $error("result moved without a judged op");
    a_judged_result: assert property (
        array_op_done_out |-> array_op_ok_out || program_error_out
        || erase_error_out)
        else $error("judged op gave no result");
    a_error_not_ok: assert property (
        program_error_out || erase_error_out |-> !array_op_ok_out)
        else $error("ok beside an error");
    a_reserved_ones: assert property (
        pointer_region_setting_out[8:0] == 9'h1FF)
        else $error("reserved pointer bits not ones");
    a_ptr_locked: assert property (
        !$stable(pointer_region_setting_out)
        |-> $past(config_unlock_flag_in))
        else $error("pointer changed while locked");
    a_idle_release: assert property (
        cs_b_in [*8] |-> !so_oe_out)
        else $error("output driven outside a frame");
    a_done_in_frame: assert property (
        array_op_done_out |-> !$past(cs_b_in, 2))
        else $error("judged op outside a frame");
endmodule
bind sector_lock_and_pointer_guard sector_guard_props chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in),
    .config_unlock_flag_in(config_unlock_flag_in),
    .so_oe_out(so_oe_out), .array_op_ok_out(array_op_ok_out),
    .array_op_done_out(array_op_done_out),
    .program_error_out(program_error_out),
    .erase_error_out(erase_error_out),
    .pointer_region_setting_out(pointer_region_setting_out));

// ===== flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
    // Link pins
    output logic sclk_out,
    output logic cs_b_out,
    output logic si_out,
    input wire so_in,
    input wire so_oe_in
);
    initial begin
        sclk_out = 1'b0;
        cs_b_out = 1'b1;
        si_out = 1'b0;
    end
    // ----------------------------------
    // One frame: opcode, address, data
    // ----------------------------------
    // Clock rests low between frames; si toggles when unused so a
    // stale bit never passes for a real one.
    task automatic frame(input logic [7:0] op, input int ab,
        input logic [31:0] adr, input int db, input logic wr,
        input logic [31:0] wd, output logic [31:0] rd);
        rd = 32'h0;
        cs_b_out <= 1'b0;
        #62.5;
        for (int i = 0; i < 8 + ab + db; i++) begin
            if (i < 8) si_out <= op[7 - i];
            else if (i < 8 + ab) si_out <= adr[ab + 7 - i];
            else if (wr) si_out <= wd[db + ab + 7 - i];
            else si_out <= ~si_out;
            #62.5 sclk_out <= 1'b1;
            if (i >= 8 + ab) rd = {rd[30:0], so_oe_in ? so_in : 1'bx};
            #62.5 sclk_out <= 1'b0;
        end
        #62.5 cs_b_out <= 1'b1;
        si_out <= ~si_out;
        #250;
    endtask
endmodule

// ===== sector_lock_and_pointer_guard_test.sv
`timescale 1ns/1ps
`include "sector_guard_map.vh"
module sector_lock_and_pointer_guard_test;
    logic clk, rst_b, srst, susp, unlk, scheme_select_bit, fourb, legacy;
    logic [7:0] guard_cfg;
    logic [31:0] rd, a;
    logic [2:0] exp_q[$];
    wire sclk, cs_b, si, so, so_oe, ok, done, perr, eerr;
    wire [31:0] ptr;
    int error_cnt = 0;
    int tests_run = 0;
    localparam logic [2:0] OK = 3'b100, PE = 3'b010, EE = 3'b001;

    sector_lock_and_pointer_guard dut (
        .clk_in(clk), .rst_b_in(rst_b), .sclk_in(sclk), .cs_b_in(cs_b),
        .si_in(si), .so_out(so), .so_oe_out(so_oe),
        .soft_reset_in(srst), .suspended_in(susp),
        .config_unlock_flag_in(unlk), .scheme_select_bit_in(scheme_select_bit),
        .four_byte_mode_in(fourb), .region_guard_config_in(guard_cfg),
        .legacy_protect_in(legacy), .array_op_ok_out(ok),
        .array_op_done_out(done), .program_error_out(perr),
        .erase_error_out(eerr), .pointer_region_setting_out(ptr));
    flash_host_model host (.sclk_out(sclk), .cs_b_out(cs_b),
        .si_out(si), .so_in(so), .so_oe_in(so_oe));

    task automatic check(input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------
    // Helpers
    // ----------------------------------
    task automatic hw_reset(input logic boot);
        @(posedge clk) rst_b <= 1'b0;
        guard_cfg <= {3'h7, boot, 4'hF};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] c, input int n, input logic [31:0] x);
        host.frame(c, n, x, 0, 1'b0, 32'h0, rd);
    endtask
    task automatic op(input logic [7:0] c, input int n, input logic [31:0] x,
        input logic [2:0] e);
        int k;
        exp_q.push_back(e);
        cmd(c, n, x);
        for (k = 0; k < 50 && exp_q.size() != 0; k++) @(posedge clk);
        if (exp_q.size() != 0) begin
            check(32'h1, 32'h0);
            end_sim;
        end
    endtask
    task automatic lock_is(input logic [31:0] x, input logic b);
        host.frame(`OP_LOCK_BIT_READ, fourb ? 32 : 24, x, 32, 1'b0, 0, rd);
        check(rd, {24'h0, {8{b}}});
    endtask
    task automatic ptr_is(input logic [31:0] v);
        host.frame(`OP_READ_ANY_REG, 32, `POINTER_REG_ADDR, 32, 1'b0, 0, rd);
        check(rd, v);
        check(ptr, v);
    endtask
    task automatic ptr_wr(input logic [31:0] v);
        host.frame(`OP_WRITE_ANY_REG, 32, `POINTER_REG_ADDR, 32, 1'b1, v, rd);
    endtask

    // Results are noted by the driver and matched here as they appear
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check({ok, perr, eerr}, exp_q.pop_front());
        end
    end
    initial forever #5 clk = ~clk;
    initial begin
        #900us;
        check(32'h1, 32'h0);
        end_sim;
    end
    // ----------------------------------
    // Main sequence
    // ----------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        srst = 1'b0;
        susp = 1'b0;
        unlk = 1'b1;
        scheme_select_bit = 1'b1;
        fourb = 1'b0;
        legacy = 1'b0;
        guard_cfg = 8'hFF;
        void'($urandom(32'hFE96));
        hw_reset(1'b1);
        // Middle blocks that a 3-byte address still reaches
        a = ((($urandom() % 252) + 2) << 16) | (($urandom() % 16) << 12);
        lock_is(a, 1'b0);
        lock_is(32'h01FFF000, 1'b0);
        cmd(`OP_SECTOR_UNLOCK, 24, a);
        lock_is(a ^ 32'hF000, 1'b1);
        cmd(`OP_SECTOR_UNLOCK, 24, 32'h1000);
        lock_is(32'h0, 1'b0);
        op(`OP_PAGE_PROGRAM, 24, 32'h0, PE);
        op(`OP_SECTOR_ERASE, 24, 32'h0, EE);
        op(`OP_PAGE_PROGRAM, 24, 32'h1000, OK);
        cmd(`OP_SECTOR_LOCK, 24, 32'h1000);
        op(`OP_SECTOR_ERASE, 24, 32'h1000, EE);
        cmd(`OP_GLOBAL_UNLOCK, 0, 32'h0);
        lock_is(32'h0, 1'b1);
        cmd(`OP_GLOBAL_LOCK, 0, 32'h0);
        lock_is(a, 1'b0);
        cmd(`OP_GLOBAL_UNLOCK, 0, 32'h0);
        @(posedge clk) fourb <= 1'b1;
        ptr_is(32'hFFFFFFFF);
        cmd(`OP_SET_POINTER_WIDE, 32, 32'hFE010000);
        ptr_is(32'hFE0101FF);
        op(`OP_PAGE_PROGRAM, 32, 32'h10000, OK);
        op(`OP_PAGE_PROGRAM, 32, 32'h11000, PE);
        op(`OP_SECTOR_ERASE, 32, 32'h0F000, OK);
        op(`OP_BLOCK_ERASE, 32, 32'h10000, EE);
        op(`OP_HALF_BLOCK_ERASE, 32, 32'h10000, EE);
        op(`OP_CHIP_ERASE, 0, 32'h0, EE);
        cmd(`OP_SET_POINTER_WIDE, 32, 32'hFE010200);
        op(`OP_PAGE_PROGRAM, 32, 32'h0F000, PE);
        op(`OP_PAGE_PROGRAM, 32, 32'h1F000, OK);
        ptr_wr(32'hFE010800);
        ptr_is(32'hFE0109FF);
        op(`OP_PAGE_PROGRAM, 32, 32'h10000, PE);
        @(posedge clk) unlk <= 1'b0;
        cmd(`OP_SET_POINTER_WIDE, 32, 32'hFFFFFFFF);
        ptr_wr(32'hFFFFFFFF);
        ptr_is(32'hFE0109FF);
        @(posedge clk) unlk <= 1'b1;
        susp <= 1'b1;
        cmd(`OP_SET_POINTER, 32, 32'hFFFFFFFF);
        ptr_is(32'hFE0109FF);
        @(posedge clk) susp <= 1'b0;
        srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        lock_is(a, 1'b0);
        cmd(`OP_SECTOR_UNLOCK, 32, 32'h01FFF000);
        lock_is(32'h01FFE000, 1'b0);
        lock_is(32'h01FFF000, 1'b1);
        ptr_is(32'hFE0109FF);
        cmd(`OP_SET_POINTER, 32, 32'hFFFFFFFF);
        ptr_is(32'hFFFFFFFF);
        op(`OP_PAGE_PROGRAM, 32, a, PE);
        @(posedge clk) scheme_select_bit <= 1'b0;
        op(`OP_PAGE_PROGRAM, 32, a, OK);
        @(posedge clk) legacy <= 1'b1;
        op(`OP_PAGE_PROGRAM, 32, a, PE);
        cmd(`OP_SET_POINTER_WIDE, 32, 32'hFE010800);
        hw_reset(1'b0);
        ptr_is(32'hFE0109FF);
        lock_is(a, 1'b1);
        check(32'(exp_q.size()), 32'h0);
        end_sim;
    end
endmodule
